// ---- bmc_map.svh ----
// Register offsets, reset values and field layout of the burst mode control block
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define BMC_OFS_ENTRY_LIMIT 8'h00
`define BMC_OFS_ERROR_LIMIT 8'h04
`define BMC_OFS_CYCLE_COUNT 8'h08
`define BMC_OFS_STATUS 8'h0c
`define BMC_OFS_EVENT_COUNT 8'h10
`define BMC_OFS_POWER_MODE 8'h34

// ****************************************************************
// Reset values and the burst power mode command
// ****************************************************************
`define BMC_RST_POWER_MODE 8'h01
`define BMC_RST_ENTRY_LIMIT 16'h0000
`define BMC_RST_ERROR_LIMIT 16'h0000
`define BMC_RST_CYCLE_COUNT 2'h0
`define BMC_POWER_MODE_BURST 8'h00

// ****************************************************************
// Fields and scaling
// ****************************************************************
`define BMC_STATUS_STATE_LSB 0
`define BMC_STATUS_ENABLE_BIT 2
`define BMC_STATUS_GATE_BIT 3
`define BMC_ERROR_LSB_UV 1250

`endif

// ---- bmc_pkg.sv ----
// Types shared by the burst mode control block
package bmc_pkg;

  typedef enum logic [1:0]
  {
    BMC_CONTINUOUS = 2'b00,
    BMC_BURST_OFF = 2'b01,
    BMC_BURST_ON = 2'b10
  } bmc_state_e;

  typedef struct packed
  {
    logic pwm_even;
    logic pwm_odd;
    logic sr_even;
    logic sr_odd;
  } bmc_drive_s;

  // Cycles per burst event from the cycle count code
  function automatic logic [3:0] bmc_reps_to_cycles(input logic [1:0] code);
    bmc_reps_to_cycles = 4'h1 << code;
  endfunction : bmc_reps_to_cycles

endpackage : bmc_pkg

// ---- bmc_burst_counter.sv ----
// Burst cycle counter that opens the switching gate for whole burst cycles
module bmc_burst_counter
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [1:0] i_reps,
  // Half-cycle pulses
  input wire logic i_even,
  input wire logic i_odd,
  // Status
  output logic o_gate,
  output logic o_done
);
  import bmc_pkg::*;

  logic armed;
  logic open;
  logic [3:0] count;
  logic prev_even;
  logic prev_odd;
  logic next_armed;
  logic next_open;
  logic [3:0] next_count;
  logic done;
  logic next_done;
  logic even_rise;
  logic odd_fall;

  assign even_rise = i_even & ~prev_even;
  assign odd_fall = ~i_odd & prev_odd;
  // Open only on an even pulse start so no partial pulse escapes
  assign o_gate = open | (armed & even_rise);
  assign o_done = done;

  always_comb
  begin
    next_armed = armed;
    next_open = open;
    next_count = count;
    next_done = 1'b0;
    if (i_abort)
    begin
      next_armed = 1'b0;
      next_open = 1'b0;
    end
    else if (i_start)
    begin
      next_armed = 1'b1;
      next_open = 1'b0;
      next_count = bmc_reps_to_cycles(i_reps);
    end
    else if (armed && even_rise)
    begin
      next_armed = 1'b0;
      next_open = 1'b1;
    end
    else if (open && odd_fall)
    begin
      // Even pulse then odd pulse ends one cycle
      next_count = count - 4'h1;
      if (count == 4'h1)
      begin
        next_open = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      armed <= 1'b0;
      open <= 1'b0;
      count <= 4'h0;
      done <= 1'b0;
      prev_even <= 1'b0;
      prev_odd <= 1'b0;
    end
    else
    begin
      armed <= next_armed;
      open <= next_open;
      count <= next_count;
      done <= next_done;
      prev_even <= i_even;
      prev_odd <= i_odd;
    end
  end

endmodule : bmc_burst_counter

// ---- bmc_burst_ctrl.sv ----
// Light-load burst mode control for the loop compensator and power stage drive
`include "bmc_map.svh"

module bmc_burst_ctrl
#(
  parameter int SENSE_W = 16,
  parameter int DUTY_W = 16
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Sensed values and target
  input wire logic [SENSE_W-1:0] i_iout_sense,
  input wire logic [SENSE_W-1:0] i_vout_sense,
  input wire logic [SENSE_W-1:0] i_vout_target,
  // Loop compensator
  input wire logic [DUTY_W-1:0] i_comp_duty,
  output logic [DUTY_W-1:0] o_duty,
  output logic o_comp_freeze,
  // Power stage drive
  input wire bmc_pkg::bmc_drive_s i_drive,
  output bmc_pkg::bmc_drive_s o_drive,
  // Status
  output logic o_burst_enable_flag,
  output logic o_burst_mode,
  output logic o_burst_on
);
  import bmc_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] power_mode;
  logic [15:0] burst_entry_current_limit;
  logic [15:0] burst_restart_error_limit;
  logic [1:0] cycle_count;
  logic [15:0] event_count;
  logic [15:0] rdata;
  logic [7:0] next_power_mode;
  logic [15:0] next_entry_limit;
  logic [15:0] next_error_limit;
  logic [1:0] next_cycle_count;
  logic [15:0] next_event_count;
  logic [15:0] next_rdata;
  logic burst_enable_flag;
  logic gate;
  logic done;
  bmc_state_e state;
  bmc_state_e next_state;

  always_comb
  begin
    next_power_mode = power_mode;
    next_entry_limit = burst_entry_current_limit;
    next_error_limit = burst_restart_error_limit;
    next_cycle_count = cycle_count;
    if (i_wr)
    begin
      case (i_addr)
        `BMC_OFS_POWER_MODE: next_power_mode = i_wdata[7:0];
        `BMC_OFS_ENTRY_LIMIT: next_entry_limit = i_wdata;
        `BMC_OFS_ERROR_LIMIT: next_error_limit = i_wdata;
        `BMC_OFS_CYCLE_COUNT: next_cycle_count = i_wdata[1:0];
        default: next_power_mode = power_mode;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    next_rdata = 16'h0000;
    if (i_rd)
    begin
      case (i_addr)
        `BMC_OFS_POWER_MODE: next_rdata = {8'h00, power_mode};
        `BMC_OFS_ENTRY_LIMIT: next_rdata = burst_entry_current_limit;
        `BMC_OFS_ERROR_LIMIT: next_rdata = burst_restart_error_limit;
        `BMC_OFS_CYCLE_COUNT: next_rdata = {14'h0000, cycle_count};
        `BMC_OFS_STATUS:
        begin
          next_rdata[`BMC_STATUS_STATE_LSB +: 2] = state;
          next_rdata[`BMC_STATUS_ENABLE_BIT] = burst_enable_flag;
          next_rdata[`BMC_STATUS_GATE_BIT] = gate;
        end
        `BMC_OFS_EVENT_COUNT: next_rdata = event_count;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_mode <= `BMC_RST_POWER_MODE;
      burst_entry_current_limit <= `BMC_RST_ENTRY_LIMIT;
      burst_restart_error_limit <= `BMC_RST_ERROR_LIMIT;
      cycle_count <= `BMC_RST_CYCLE_COUNT;
      rdata <= 16'h0000;
    end
    else
    begin
      power_mode <= next_power_mode;
      burst_entry_current_limit <= next_entry_limit;
      burst_restart_error_limit <= next_error_limit;
      cycle_count <= next_cycle_count;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;

  // ****************************************************************
  // Enable flag
  // ****************************************************************
  // Flag mirrors the power mode command being zero
  assign burst_enable_flag = (power_mode == `BMC_POWER_MODE_BURST);

  // ****************************************************************
  // Thresholds
  // ****************************************************************
  logic [SENSE_W:0] iout_half_lsb;
  logic [SENSE_W:0] entry_limit_ext;
  logic signed [SENSE_W+1:0] vout_error;
  logic signed [SENSE_W+1:0] error_limit_ext;
  logic low_current;
  logic restart_due;

  // Sensed current in quantum units doubled to half-quantum units
  assign iout_half_lsb = {i_iout_sense, 1'b0};
  assign entry_limit_ext = (SENSE_W + 1)'(burst_entry_current_limit);
  assign low_current = iout_half_lsb < entry_limit_ext;
  // Both values in 1.25 mV counts at the sense input
  assign vout_error = $signed({2'b00, i_vout_target}) - $signed({2'b00, i_vout_sense});
  // Zero-extended, so the limit never goes negative
  assign error_limit_ext = $signed((SENSE_W + 2)'(burst_restart_error_limit));
  assign restart_due = vout_error > error_limit_ext;

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  logic start_burst;
  logic abort_burst;

  always_comb
  begin
    next_state = state;
    start_burst = 1'b0;
    abort_burst = 1'b0;
    case (state)
      BMC_CONTINUOUS:
      begin
        if (burst_enable_flag && low_current)
        begin
          next_state = BMC_BURST_OFF;
        end
      end
      BMC_BURST_OFF:
      begin
        if (!burst_enable_flag)
        begin
          next_state = BMC_CONTINUOUS;
        end
        else if (restart_due)
        begin
          next_state = BMC_BURST_ON;
          start_burst = 1'b1;
        end
      end
      BMC_BURST_ON:
      begin
        if (!burst_enable_flag)
        begin
          next_state = BMC_CONTINUOUS;
          abort_burst = 1'b1;
        end
        else if (done)
        begin
          next_state = BMC_BURST_OFF;
        end
      end
      default:
      begin
        next_state = BMC_CONTINUOUS;
        abort_burst = 1'b1;
      end
    endcase
  end

  bmc_burst_counter u_counter
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_start(start_burst),
    .i_abort(abort_burst),
    .i_reps(cycle_count),
    .i_even(i_drive.pwm_even),
    .i_odd(i_drive.pwm_odd),
    .o_gate(gate),
    .o_done(done)
  );

  // ****************************************************************
  // Duty freeze and drive gating
  // ****************************************************************
  logic [DUTY_W-1:0] held_duty;
  logic [DUTY_W-1:0] next_held_duty;
  logic [DUTY_W-1:0] duty;
  logic [DUTY_W-1:0] next_duty;
  bmc_drive_s drive;
  bmc_drive_s next_drive;
  logic in_burst;
  logic next_in_burst;

  assign in_burst = (state != BMC_CONTINUOUS);
  assign next_in_burst = (next_state != BMC_CONTINUOUS);

  always_comb
  begin
    next_held_duty = held_duty;
    if (!in_burst && next_in_burst)
    begin
      next_held_duty = i_comp_duty;
    end
    next_duty = next_in_burst ? next_held_duty : i_comp_duty;
    next_drive = i_drive;
    // Gated from next state so drive and mode change on one edge
    if (next_in_burst)
    begin
      next_drive.pwm_even = (next_state == BMC_BURST_ON) && gate && i_drive.pwm_even;
      next_drive.pwm_odd = (next_state == BMC_BURST_ON) && gate && i_drive.pwm_odd;
      next_drive.sr_even = 1'b0;
      next_drive.sr_odd = 1'b0;
    end
    next_event_count = event_count + {15'h0000, start_burst};
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= BMC_CONTINUOUS;
      held_duty <= '0;
      duty <= '0;
      drive <= '0;
      event_count <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      held_duty <= next_held_duty;
      duty <= next_duty;
      drive <= next_drive;
      event_count <= next_event_count;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_duty = duty;
  assign o_drive = drive;
  assign o_comp_freeze = in_burst;
  assign o_burst_enable_flag = burst_enable_flag;
  assign o_burst_mode = in_burst;
  assign o_burst_on = (state == BMC_BURST_ON);

endmodule : bmc_burst_ctrl

// ---- bmc_burst_assertions.sv ----
// Port checker of the burst mode control block
module bmc_burst_assertions
#(
  parameter int SENSE_W = 16,
  parameter int DUTY_W = 16
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [SENSE_W-1:0] i_vout_sense,
  input wire logic [SENSE_W-1:0] i_vout_target,
  input wire logic [DUTY_W-1:0] i_comp_duty,
  input wire logic [DUTY_W-1:0] o_duty,
  input wire logic o_comp_freeze,
  input wire bmc_pkg::bmc_drive_s o_drive,
  input wire logic o_burst_enable_flag,
  input wire logic o_burst_mode,
  input wire logic o_burst_on
);
  import bmc_pkg::*;
  // ****
  // Settling after reset
  // ****
  logic [2:0] up;
  logic [2:0] next_up;
  logic err_pos;
  assign next_up = up[2] ? up : up + 3'h1;
  assign err_pos = i_vout_target > i_vout_sense;
  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
      up <= 3'h0;
    else
      up <= next_up;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  sequence s_flag_off2;
    !o_burst_enable_flag ##1 !o_burst_enable_flag;
  endsequence
  sequence s_held;
    o_burst_mode ##1 o_burst_mode;
  endsequence
  chk_sr_held_off: assert property (o_burst_mode |-> !o_drive.sr_even && !o_drive.sr_odd)
    else $error("rectifier drive in burst");
  chk_off_silent: assert property (o_burst_mode && !o_burst_on |-> o_drive == 4'h0)
    else $error("switching in burst off");
  chk_freeze_capture: assert property ($rose(o_comp_freeze) |-> o_duty == $past(i_comp_duty))
    else $error("duty not captured at entry");
  chk_duty_frozen: assert property (s_held |-> $stable(o_duty))
    else $error("duty moved in burst");
  chk_duty_follow: assert property (up[2] && !o_burst_mode && !$past(o_burst_mode)
    |-> o_duty == $past(i_comp_duty))
    else $error("duty not following");
  chk_exit_on_clear: assert property (s_flag_off2 |-> !o_burst_mode)
    else $error("burst without enable");
  chk_entry_enabled: assert property ($rose(o_burst_mode) |-> $past(o_burst_enable_flag))
    else $error("entry while disabled");
  chk_start_below: assert property ($rose(o_burst_on) |-> $past(o_burst_mode) && $past(err_pos))
    else $error("burst start above target");
  chk_on_needs_flag: assert property (o_burst_on && $past(o_burst_on)
    |-> $past(o_burst_enable_flag))
    else $error("burst on kept without enable");
endmodule : bmc_burst_assertions

bind bmc_burst_ctrl bmc_burst_assertions #(.SENSE_W(SENSE_W), .DUTY_W(DUTY_W)) u_chk
(
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_vout_sense(i_vout_sense),
  .i_vout_target(i_vout_target),
  .i_comp_duty(i_comp_duty),
  .o_duty(o_duty),
  .o_comp_freeze(o_comp_freeze),
  .o_drive(o_drive),
  .o_burst_enable_flag(o_burst_enable_flag),
  .o_burst_mode(o_burst_mode),
  .o_burst_on(o_burst_on)
);

// ---- bmc_drive_model.sv ----
// Modulator stand-in making even and odd half-cycle pulses
module bmc_drive_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  output bmc_pkg::bmc_drive_s o_drive
);
  import bmc_pkg::*;
  logic [2:0] ph;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      ph <= 3'h0;
    else
      ph <= ph + 3'h1;
  // Even pulse, then odd pulse, rectifiers in the gaps
  assign o_drive = bmc_drive_s'{ph == 3'h1 || ph == 3'h2, ph == 3'h5 || ph == 3'h6,
    ph == 3'h3, ph == 3'h7};
endmodule : bmc_drive_model

// ---- bmc_burst_ctrl_test.sv ----
// Self-checking bench of the burst mode control block
`include "bmc_map.svh"
`define CHK(a, b) \
  begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module bmc_burst_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bmc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] iout = 16'hffff;
  logic [15:0] tgt = 16'h1000;
  logic [15:0] vout = 16'h1000;
  logic [15:0] cdut = 16'h0000;
  logic [15:0] rdata, duty, lim, elim, d0, d1;
  logic freeze, flag, mode, on, pe, po;
  bmc_drive_s drv_in, drv_out;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_even = 0, n_odd = 0, e0, o0;
  initial
    forever #5 clk = ~clk;
  bmc_drive_model u_mod
  (
    .i_clk_sys(clk),
    .i_rst_n(rstn),
    .o_drive(drv_in)
  );
  bmc_burst_ctrl dut
  (
    .i_clk_sys(clk),
    .i_rstn(rstn),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .i_iout_sense(iout),
    .i_vout_sense(vout),
    .i_vout_target(tgt),
    .i_comp_duty(cdut),
    .o_duty(duty),
    .o_comp_freeze(freeze),
    .i_drive(drv_in),
    .o_drive(drv_out),
    .o_burst_enable_flag(flag),
    .o_burst_mode(mode),
    .o_burst_on(on)
  );
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ****
  // Pulse counting and timeout
  // ****
  always @(posedge clk)
  begin
    cyc++;
    pe <= drv_out.pwm_even;
    po <= drv_out.pwm_odd;
    if (on && drv_out.pwm_even && !pe)
      n_even++;
    if (on && drv_out.pwm_odd && !po)
      n_odd++;
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic wait_lvl(input bit sel_on, input logic v);
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk);
      #1;
      if ((sel_on ? on : mode) === v)
        break;
    end
    `CHK(sel_on ? on : mode, v)
  endtask : wait_lvl
  initial
  begin
    void'($urandom(68950));
    lim = 16'(2 * (10 + $urandom % 500) + 1);
    elim = 16'(1 + $urandom % 200);
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`BMC_OFS_POWER_MODE, 16'h0001);
    rd_chk(8'h20, 16'h0000);
    wr_reg(`BMC_OFS_ENTRY_LIMIT, lim);
    wr_reg(`BMC_OFS_ERROR_LIMIT, elim);
    cdut <= d0;
    iout <= lim >> 1;
    wr_reg(`BMC_OFS_POWER_MODE, 16'(1 + $urandom % 255));
    repeat (5) @(posedge clk);
    `CHK(flag, 1'b0)
    `CHK(mode, 1'b0)
    iout <= (lim >> 1) + 16'h0001;
    wr_reg(`BMC_OFS_POWER_MODE, 16'h0000);
    repeat (4) @(posedge clk);
    `CHK(flag, 1'b1)
    `CHK(mode, 1'b0)
    iout <= lim >> 1;
    wait_lvl(1'b0, 1'b1);
    @(posedge clk);
    cdut <= d1;
    rd_chk(`BMC_OFS_STATUS, 16'h0005);
    for (int code = 0; code < 4; code++)
    begin
      wr_reg(`BMC_OFS_CYCLE_COUNT, 16'(code));
      e0 = n_even;
      o0 = n_odd;
      vout <= tgt - elim;
      repeat (4) @(posedge clk);
      `CHK(on, 1'b0)
      vout <= tgt - elim - 16'h0001;
      wait_lvl(1'b1, 1'b1);
      @(posedge clk);
      vout <= tgt;
      wait_lvl(1'b1, 1'b0);
      repeat (2) @(posedge clk);
      `CHK(n_even - e0, 1 << code)
      `CHK(n_odd - o0, 1 << code)
      `CHK(duty, d0)
      `CHK(freeze, 1'b1)
    end
    rd_chk(`BMC_OFS_EVENT_COUNT, 16'h0004);
    wr_reg(`BMC_OFS_POWER_MODE, 16'h0001);
    wait_lvl(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK(duty, d1)
    `CHK(freeze, 1'b0)
    conclude();
  end
endmodule : bmc_burst_ctrl_test
